// >>> logic/asr_host.sv
// Purpose: Host controller driving an asynchronous 8K x 8 static memory
// Assumes: 100 MHz clock; memory pins sampled synchronously
// Notes: One request at a time; all pin outputs come from flip-flops
// Notes on behaviour
// RQ1 - Memory holds 8192 words of 8 bits, 13-bit address, shared data bus.
// RQ2 - Deselected memory is in standby with data lines floating.
// RQ3 - Read: both selects on, store strobe high, drive enable low.
// RQ4 - Write happens only while both selects on and store strobe low.
// RQ5 - After a read the memory powers down and keeps data latched.
// RQ6 - Same word on consecutive reads stays glitch free.
// RQ7 - Host presents address before the last select is asserted; host sets address and selects on the same edge.
// RQ8 - Host keeps address driven while selected.
// RQ9 - Select timings count from later assert and first deassert.
// RQ10 - Read cycle at least 85 ns; data valid within 85 ns.
// RQ11 - Outputs float again within 35 ns; old data held 10 ns.
// RQ12 - Write cycle at least 85 ns; select and address 70 ns before end.
// RQ13 - Store strobe low 40 ns; data 35 ns before, 5 ns after end.
// RQ14 - Wait 5 ns recovery after write end before changing address.
// RQ15 - Select asserted with or after strobe fall keeps outputs floating.
// RQ16 - With drive enable low, outputs off within 35 ns of strobe.
// RQ17 - Outputs during such a write show the data written.
// RQ18 - After write and address change, outputs show next stored word.
// RQ19 - Host never drives data while the memory drives the bus.
// RQ20 - Deselect at full rail before supply drops for retention.
// RQ21 - After retention stay deselected one read cycle before access.
// RQ22 - Memory is clockless; contents undefined until written.
module asr_host
  import asr_pkg::*;
#(
  parameter int ADDR_W = ASR_ADDR_W,
  parameter int DATA_W = ASR_DATA_W
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RST_B,
  input wire logic I_REQ,
  input wire logic I_REQ_WRITE,
  input wire logic [ADDR_W-1:0] I_REQ_ADDR,
  input wire logic [DATA_W-1:0] I_REQ_WDATA,
  input wire logic I_RET_ENTER,
  input wire logic I_RET_EXIT,
  input wire logic [DATA_W-1:0] I_MEM_DATA,
  output logic O_REQ_READY,
  output logic O_RD_VALID,
  output logic [DATA_W-1:0] O_RD_DATA,
  output logic O_WR_DONE,
  output logic O_RET_ACTIVE,
  output logic [ADDR_W-1:0] O_MEM_ADDR,
  output logic O_SELECT_ACTIVE_LOW_B,
  output logic O_SELECT_ACTIVE_HIGH,
  output logic O_DRIVE_EN_B,
  output logic O_STORE_B,
  output logic [DATA_W-1:0] O_MEM_DATA,
  output logic O_MEM_DATA_OE
);
  asr_state_e state_r;
  asr_tmr_if tmr ();
  logic load_r;
  logic [ASR_CNT_W-1:0] count_r;
  assign tmr.load = load_r;
  assign tmr.count = count_r;

  asr_timer u_timer (
    .i_clk(I_CLK_SYS),
    .i_rst_b(I_RST_B),
    .t(tmr)
  );

  // Phase sequencing; each phase except idle and retention loads the timer on entry
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      state_r <= ASR_IDLE;
      load_r <= 1'b0;
      count_r <= '0;
    end else begin
      load_r <= 1'b0;
      unique case (state_r)
        ASR_IDLE: begin
          if (I_RET_ENTER) begin
            state_r <= ASR_RET; // [RQ20]
          end else if (I_REQ && I_REQ_WRITE) begin
            state_r <= ASR_WR_SET;
            load_r <= 1'b1;
            count_r <= ASR_CNT_W'(ASR_WCYC_CYC - ASR_STORE_CYC - ASR_RECOV_CYC);
          end else if (I_REQ) begin
            state_r <= ASR_RD;
            load_r <= 1'b1;
            count_r <= ASR_CNT_W'(ASR_READ_CYC); // [RQ10]
          end
        end
        ASR_RD: begin
          if (tmr.done) begin
            state_r <= ASR_RD_HIZ;
            load_r <= 1'b1;
            count_r <= ASR_CNT_W'(ASR_HIZ_CYC); // [RQ11] [RQ19]
          end
        end
        ASR_WR_SET: begin
          if (tmr.done) begin
            state_r <= ASR_WR_PULSE;
            load_r <= 1'b1;
            count_r <= ASR_CNT_W'(ASR_STORE_CYC); // [RQ13]
          end
        end
        ASR_WR_PULSE: begin
          if (tmr.done) begin
            state_r <= ASR_WR_REC;
            load_r <= 1'b1;
            count_r <= ASR_CNT_W'(ASR_RECOV_CYC); // [RQ14]
          end
        end
        ASR_RET: begin
          if (I_RET_EXIT) begin
            state_r <= ASR_RET_EXIT;
            load_r <= 1'b1;
            count_r <= ASR_CNT_W'(ASR_RET_EXIT_CYC); // [RQ21]
          end
        end
        ASR_RD_HIZ, ASR_WR_REC, ASR_RET_EXIT: begin
          if (tmr.done) begin
            state_r <= ASR_IDLE;
          end
        end
      endcase
    end
  end

  // Pin drive; address changes and selects assert only in idle, never mid-cycle
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_MEM_ADDR <= '0; // [RQ8]
      O_SELECT_ACTIVE_LOW_B <= 1'b1;
      O_SELECT_ACTIVE_HIGH <= 1'b0; // [RQ2]
      O_DRIVE_EN_B <= 1'b1;
      O_STORE_B <= 1'b1;
      O_MEM_DATA <= '0;
      O_MEM_DATA_OE <= 1'b0;
    end else begin
      unique case (state_r)
        ASR_IDLE: begin
          if (I_REQ && !I_RET_ENTER) begin
            // Address and selects move together: valid no later than select
            O_MEM_ADDR <= I_REQ_ADDR; // [RQ7]
            O_SELECT_ACTIVE_LOW_B <= 1'b0;
            O_SELECT_ACTIVE_HIGH <= 1'b1; // [RQ9]
            O_DRIVE_EN_B <= I_REQ_WRITE; // [RQ3]
            O_STORE_B <= 1'b1;
            O_MEM_DATA <= I_REQ_WDATA;
            O_MEM_DATA_OE <= I_REQ_WRITE;
          end else begin
            O_SELECT_ACTIVE_LOW_B <= 1'b1;
            O_SELECT_ACTIVE_HIGH <= 1'b0;
          end
        end
        ASR_RD: begin
          if (tmr.done) begin
            O_SELECT_ACTIVE_LOW_B <= 1'b1;
            O_SELECT_ACTIVE_HIGH <= 1'b0;
            O_DRIVE_EN_B <= 1'b1;
          end
        end
        ASR_WR_SET: begin
          // Drive enable stays high so the memory never fights our data
          if (tmr.done) begin
            O_STORE_B <= 1'b0; // [RQ4] [RQ12]
          end
        end
        ASR_WR_PULSE: begin
          if (tmr.done) begin
            O_STORE_B <= 1'b1; // [RQ13]
            O_SELECT_ACTIVE_LOW_B <= 1'b1;
            O_SELECT_ACTIVE_HIGH <= 1'b0;
          end
        end
        ASR_WR_REC: begin
          if (tmr.done) begin
            O_MEM_DATA_OE <= 1'b0; // [RQ13]
          end
        end
        ASR_RET, ASR_RET_EXIT, ASR_RD_HIZ: begin
          // Full-rail deselect held across retention and its exit
          O_SELECT_ACTIVE_LOW_B <= 1'b1; // [RQ20]
          O_SELECT_ACTIVE_HIGH <= 1'b0;
          O_MEM_DATA_OE <= 1'b0;
        end
      endcase
    end
  end

  // Host-side status
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_REQ_READY <= 1'b0;
      O_RD_VALID <= 1'b0;
      O_RD_DATA <= '0;
      O_WR_DONE <= 1'b0;
      O_RET_ACTIVE <= 1'b0;
    end else begin
      O_REQ_READY <= (state_r == ASR_IDLE) && !I_REQ && !I_RET_ENTER;
      O_RD_VALID <= (state_r == ASR_RD) && tmr.done;
      if ((state_r == ASR_RD) && tmr.done) begin
        O_RD_DATA <= I_MEM_DATA; // [RQ10]
      end
      O_WR_DONE <= (state_r == ASR_WR_REC) && tmr.done;
      O_RET_ACTIVE <= (state_r == ASR_RET);
    end
  end
endmodule // asr_host

// >>> common/asr_pkg.sv
// Purpose: Shared constants for the static memory host controller
// Assumes: 100 MHz system clock
// Notes: Times are in ns; cycle counts are derived from them
package asr_pkg;
  localparam int ASR_CLK_NS = 10;
  localparam int ASR_ADDR_W = 13;
  localparam int ASR_DATA_W = 8;
  localparam int ASR_DEPTH = 8192;
  // Least times round up, never below one cycle
  function automatic int asr_cyc_min(input int t_ns);
    int c;
    c = (t_ns + ASR_CLK_NS - 1) / ASR_CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int ASR_READ_CYCLE_MIN_NS = 85;
  localparam int ASR_READ_ACCESS_NS = 85;
  localparam int ASR_WRITE_CYCLE_NS = 85;
  localparam int ASR_STORE_PULSE_MIN_NS = 40;
  localparam int ASR_DATA_SETUP_NS = 35;
  localparam int ASR_DATA_HOLD_NS = 5;
  localparam int ASR_RECOVERY_AFTER_STORE_NS = 5;
  localparam int ASR_OUT_HIZ_NS = 35;
  localparam int ASR_DESELECT_BEFORE_RETENTION_NS = 0;
  localparam int ASR_RETENTION_EXIT_DELAY_NS = 85;
  localparam int ASR_READ_CYC = asr_cyc_min(ASR_READ_ACCESS_NS) + 1;
  localparam int ASR_STORE_CYC = asr_cyc_min(ASR_STORE_PULSE_MIN_NS);
  localparam int ASR_WCYC_CYC = asr_cyc_min(ASR_WRITE_CYCLE_NS);
  localparam int ASR_RECOV_CYC = asr_cyc_min(ASR_RECOVERY_AFTER_STORE_NS);
  localparam int ASR_HIZ_CYC = asr_cyc_min(ASR_OUT_HIZ_NS);
  localparam int ASR_RET_EXIT_CYC = asr_cyc_min(ASR_RETENTION_EXIT_DELAY_NS);
  localparam int ASR_CNT_W = 5;
  typedef enum {ASR_IDLE, ASR_RD, ASR_RD_HIZ, ASR_WR_SET, ASR_WR_PULSE, ASR_WR_REC,
    ASR_RET, ASR_RET_EXIT} asr_state_e;
endpackage

// >>> common/asr_tmr_if.sv
// Purpose: Load/expire handshake between controller and its cycle timer
// Assumes: Single clock domain
// Notes: Load is a one-cycle pulse
interface asr_tmr_if;
  logic load;
  logic [asr_pkg::ASR_CNT_W-1:0] count;
  logic done;
  modport ctl (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface

// >>> logic/asr_timer.sv
// Purpose: Down counter that times each phase of a memory cycle
// Assumes: Count loaded is at least one
// Notes: done is high once the loaded number of cycles has passed
module asr_timer
  import asr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  asr_tmr_if.tmr t
);
  logic [ASR_CNT_W-1:0] cnt_r;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_r <= '0;
    end else if (t.load) begin
      cnt_r <= t.count - ASR_CNT_W'(1);
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - ASR_CNT_W'(1);
    end
  end
  assign t.done = (cnt_r == '0) && !t.load;
endmodule // asr_timer

// >>> test/asr_host_properties.sv
// Purpose: Pin timing checks for the static memory host
// Assumes: One clock; pins sampled at its rising edge
// Notes: Watches only what the host drives
module asr_host_properties
  import asr_pkg::*;
#(parameter int ADDR_W = ASR_ADDR_W, parameter int DATA_W = ASR_DATA_W) (
  input wire logic I_CLK_SYS,
  input wire logic I_RST_B,
  input wire logic O_RD_VALID,
  input wire logic O_RET_ACTIVE,
  input wire logic [ADDR_W-1:0] O_MEM_ADDR,
  input wire logic O_SELECT_ACTIVE_LOW_B,
  input wire logic O_SELECT_ACTIVE_HIGH,
  input wire logic O_DRIVE_EN_B,
  input wire logic O_STORE_B,
  input wire logic [DATA_W-1:0] O_MEM_DATA,
  input wire logic O_MEM_DATA_OE
);
  logic sel;
  logic rd;
  assign sel = !O_SELECT_ACTIVE_LOW_B && O_SELECT_ACTIVE_HIGH;
  assign rd = sel && !O_DRIVE_EN_B;
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_B);
  sequence s_rd_open; $rose(rd); endsequence
  sequence s_store_end; $rose(O_STORE_B); endsequence
  a_no_bus_fight: assert property (O_MEM_DATA_OE |-> !rd)
    else $error("bus fight");
  a_read_answer: assert property (s_rd_open |-> ##[9:12] O_RD_VALID)
    else $error("read answer late");
  a_addr_held: assert property (sel && $past(sel) |-> $stable(O_MEM_ADDR))
    else $error("address moved while selected");
  a_store_pulse: assert property ($fell(O_STORE_B) |-> (sel && !O_STORE_B) [*4])
    else $error("store pulse short");
  a_write_window: assert property (s_store_end |-> $past(sel, 7) && $past(sel)
    && $past(O_MEM_ADDR, 7) == O_MEM_ADDR)
    else $error("write window short");
  a_data_setup: assert property (s_store_end |-> O_MEM_DATA_OE
    && $past(O_MEM_DATA_OE, 4) && $past(O_MEM_DATA, 4) == O_MEM_DATA)
    else $error("write data setup");
  a_store_recovery: assert property (s_store_end |=> $stable(O_MEM_ADDR))
    else $error("no recovery");
  // Nine samples: eight cycles alone would be short of one full read cycle time
  a_ret_recover: assert property ($fell(O_RET_ACTIVE) |-> !sel [*8] ##1 !sel)
    else $error("selected too soon after retention");
endmodule // asr_host_properties

bind asr_host asr_host_properties #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (
  .I_CLK_SYS(I_CLK_SYS), .I_RST_B(I_RST_B), .O_RD_VALID(O_RD_VALID),
  .O_RET_ACTIVE(O_RET_ACTIVE), .O_MEM_ADDR(O_MEM_ADDR),
  .O_SELECT_ACTIVE_LOW_B(O_SELECT_ACTIVE_LOW_B), .O_SELECT_ACTIVE_HIGH(O_SELECT_ACTIVE_HIGH),
  .O_DRIVE_EN_B(O_DRIVE_EN_B), .O_STORE_B(O_STORE_B), .O_MEM_DATA(O_MEM_DATA),
  .O_MEM_DATA_OE(O_MEM_DATA_OE));

// >>> test/asr_mem_model.sv
// Purpose: Behavioural 8K x 8 static memory on the host pins
// Assumes: Zero delay; reacts to pin levels, no clock
// Notes: Resolves the shared data lines for the host
module asr_mem_model
  import asr_pkg::*;
(
  input wire logic [ASR_ADDR_W-1:0] i_addr,
  input wire logic i_sel_lo_b,
  input wire logic i_sel_hi,
  input wire logic i_drive_en_b,
  input wire logic i_store_b,
  input wire logic [ASR_DATA_W-1:0] i_host_d,
  input wire logic i_host_oe,
  output logic [ASR_DATA_W-1:0] o_bus
);
  logic [ASR_DATA_W-1:0] mem [ASR_DEPTH];
  logic [ASR_DATA_W-1:0] q_r;
  logic sel;
  logic drv;
  assign sel = !i_sel_lo_b && i_sel_hi;
  assign drv = sel && !i_drive_en_b && i_store_b;
  always @* if (sel && !i_store_b) mem[i_addr] = o_bus;
  always @* if (drv) q_r = mem[i_addr];
  // Released lines show the inverse of the last word, so a stale sample cannot match
  assign o_bus = i_host_oe ? i_host_d : (drv ? q_r : ~q_r);
endmodule // asr_mem_model

// >>> test/tb_asr_host.sv
// Purpose: Self-checking bench for the static memory host
// Assumes: 100 MHz clock, bench drives inputs by NBA at rising edges
// Notes: Read latency window allows one cycle either way; write window runs from ASR_WCYC_CYC to three above
module tb_asr_host
  import asr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_b = 0, req = 0, wr = 0, ret_in = 0, ret_out = 0;
  logic [12:0] addr = '0;
  logic [7:0] wd = '0;
  logic rdy, rv, wdone, ret_act, sl_b, sh, oe_b, st_b, doe;
  logic [12:0] ma;
  logic [7:0] rdat, md, bus;
  int err_count = 0, n_compared = 0, cyc = 0;
  asr_host u_dut (.I_CLK_SYS(clk), .I_RST_B(rst_b), .I_REQ(req), .I_REQ_WRITE(wr),
    .I_REQ_ADDR(addr), .I_REQ_WDATA(wd), .I_RET_ENTER(ret_in), .I_RET_EXIT(ret_out),
    .I_MEM_DATA(bus), .O_REQ_READY(rdy), .O_RD_VALID(rv), .O_RD_DATA(rdat),
    .O_WR_DONE(wdone), .O_RET_ACTIVE(ret_act), .O_MEM_ADDR(ma),
    .O_SELECT_ACTIVE_LOW_B(sl_b), .O_SELECT_ACTIVE_HIGH(sh), .O_DRIVE_EN_B(oe_b),
    .O_STORE_B(st_b), .O_MEM_DATA(md), .O_MEM_DATA_OE(doe));
  asr_mem_model u_mem (.i_addr(ma), .i_sel_lo_b(sl_b), .i_sel_hi(sh), .i_drive_en_b(oe_b),
    .i_store_b(st_b), .i_host_d(md), .i_host_oe(doe), .o_bus(bus));
  initial forever #5 clk = ~clk;
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      test_done();
    end
  end
  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic xfer(input logic w, input logic [12:0] a, input logic [7:0] d, output int n);
    n = 0;
    while (rdy !== 1'b1) tick;
    @(posedge clk);
    {req, wr, addr, wd} <= {1'b1, w, a, d};
    @(posedge clk);
    req <= 1'b0;
    do begin
      tick;
      n++;
    end while ((w ? wdone : rv) !== 1'b1 && n < 40);
  endtask
  task automatic t_rw;
    int n;
    int k;
    logic [12:0] a [3] = '{13'h0000, 13'h00a5, 13'h1fff};
    logic [7:0] d [3] = '{8'h5a, 8'hc3, 8'h81};
    chk({sl_b, sh, st_b, oe_b, doe, rdy} === 6'b101101, "idle pins");
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, a[i], d[i], n);
      chk(n >= ASR_WCYC_CYC && n <= ASR_WCYC_CYC + 3, "write latency");
    end
    for (int i = 0; i < 4; i++) begin
      k = i % 3 + i / 3 * 2;
      xfer(1'b0, a[k], 8'h00, n);
      chk(rdat === d[k], "read data");
      chk(n >= 10 && n <= 12, "read latency");
    end
    $display("t_rw done");
  endtask
  task automatic t_ret;
    int n;
    // Retention is only taken in idle; the read before leaves a float gap
    while (rdy !== 1'b1) tick;
    @(posedge clk);
    ret_in <= 1'b1;
    @(posedge clk);
    ret_in <= 1'b0;
    repeat (3) tick;
    chk(ret_act === 1'b1 && (sl_b === 1'b1 || sh === 1'b0), "retention");
    @(posedge clk);
    ret_out <= 1'b1;
    @(posedge clk);
    ret_out <= 1'b0;
    n = 0;
    while (rdy !== 1'b1 && n < 40) begin
      tick;
      n++;
    end
    chk(n >= ASR_RET_EXIT_CYC && n < 40, "recovery time");
    xfer(1'b0, 13'h0000, 8'h00, n);
    chk(rdat === 8'h5a, "retained word");
    $display("t_ret done");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) tick;
    t_rw();
    t_ret();
    test_done();
  end
endmodule // tb_asr_host
